// ### core/nvt_pkg.sv
// Shared constants and types for the program flash table access block.
`default_nettype none
package nvt_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_UNLOCK = 8'h04;
  localparam logic [7:0] OFF_LATCH = 8'h08;
  localparam logic [7:0] OFF_PTR = 8'h0C;
  localparam logic [7:0] OFF_TCMD = 8'h10;
  localparam logic [7:0] OFF_EEPROM_DATA_REG = 8'h14;
  localparam logic [7:0] OFF_EEADDR = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  // Control register bit positions.
  localparam int CB_PGM = 7;
  localparam int CB_CFG = 6;
  localparam int CB_FREE = 4;
  localparam int CB_ABORT = 3;
  localparam int CB_PERMIT = 2;
  localparam int CB_WR = 1;
  localparam int CB_RD = 0;
  // Status register bit positions.
  localparam int SB_DONE = 0;
  localparam int SB_BUSY = 1;
  // Unlock keys, written in this order to the unlock port.
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  // Table pointer geometry.
  localparam int PTR_W = 22;
  localparam int PTR_STEP_W = 21;
  localparam int HOLD_N = 8;
  localparam int ERASE_N = 64;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Self-timed programming time and its cycle count.
  localparam int PROG_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_CYCLES =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pointer update modes of a table instruction.
  typedef enum logic [1:0] {
    PTR_KEEP = 2'h0,
    PTR_POSTINC = 2'h1,
    PTR_POSTDEC = 2'h2,
    PTR_PREINC = 2'h3
  } nvt_ptr_mode_t;
  // Programming sequencer states; one bit changes per step, except from done back to idle.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PROG = 2'h1,
    ST_DONE = 2'h3
  } nvt_state_t;
  // Target memory of a self-timed operation.
  typedef enum logic [1:0] {
    TGT_EE = 2'h0,
    TGT_FLASH = 2'h1,
    TGT_CFG = 2'h2
  } nvt_target_t;
  // Control register fields as stored.
  typedef struct packed {
    logic pgm;
    logic cfg;
    logic free;
    logic abort;
    logic permit;
    logic wr;
    logic rd;
  } nvt_ctrl_t;
endpackage
`default_nettype wire

// ### core/nvt_table_access.sv
// Program flash table access, self-programming control and AXI4-Lite slave.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
module nvt_table_access #(
  parameter int FLASH_AW = 12,
  parameter int EE_AW = 8,
  parameter int CFG_AW = 4,
  parameter int PROG_CYCLES = nvt_pkg::PROG_CYCLES
) (
  // Clock and resets.
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PWR_ON_RST,
  // AXI4-Lite write address channel.
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data channel.
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response channel.
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address channel.
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data channel.
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Instruction fetch port of the core.
  input wire logic [FLASH_AW-2:0] FETCH_ADDR,
  output logic [15:0] FETCH_WORD,
  output logic FETCH_STALL,
  // Write-complete flag towards the interrupt controller.
  output logic NVM_DONE_IRQ
);

  // Storage arrays; flash holds bytes, fetched as little-endian words.
  logic [7:0] flash_mem [2**FLASH_AW];
  logic [7:0] ee_mem [2**EE_AW];
  logic [7:0] cfg_mem [2**CFG_AW];
  logic [7:0] hold_r [nvt_pkg::HOLD_N];

  // Block registers.
  nvt_pkg::nvt_ctrl_t ctrl_r;
  logic [7:0] latch_r;
  logic [nvt_pkg::PTR_W-1:0] ptr_r;
  logic [7:0] eeprom_data_reg_r;
  logic [7:0] eeaddr_r;
  logic done_r;
  logic [1:0] unlock_r;
  nvt_pkg::nvt_state_t state_r;
  nvt_pkg::nvt_target_t tgt_r;
  logic erase_r;
  logic [nvt_pkg::PTR_W-1:0] prog_ptr_r;
  logic [15:0] timer_r;

  // Bus slave state.
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Decoded pulses.
  logic wr_en;
  logic prog_end;
  logic tbl_go;
  logic [2:0] tbl_cmd;
  logic [nvt_pkg::PTR_W-1:0] tbl_addr;
  logic start_ok;
  logic busy;

  // Pointer update on the low bits only; the top bit never carries.
  function automatic logic [nvt_pkg::PTR_W-1:0] ptr_step(
    input logic [nvt_pkg::PTR_W-1:0] p, input logic dn);
    logic [nvt_pkg::PTR_STEP_W-1:0] lo;
    lo = p[nvt_pkg::PTR_STEP_W-1:0];
    lo = dn ? lo - 1'b1 : lo + 1'b1;
    return {p[nvt_pkg::PTR_W-1], lo};
  endfunction

  // True when the offset names one of the mapped registers.
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= nvt_pkg::OFF_STATUS;
  endfunction

  // Byte seen by a table read; top pointer bit opens config space.
  function automatic logic [7:0] table_byte(
    input logic [nvt_pkg::PTR_W-1:0] a);
    if (a[nvt_pkg::PTR_W-1]) begin
      return cfg_mem[a[CFG_AW-1:0]];
    end
    return flash_mem[a[FLASH_AW-1:0]];
  endfunction

  // Handshake outputs are combinational from the hold and valid flags.
  assign S_AXI_AWREADY = !aw_hold_r && !bvalid_r;
  assign S_AXI_WREADY = !w_hold_r && !bvalid_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign NVM_DONE_IRQ = done_r;

  // A register write happens once both halves have been taken.
  assign wr_en = aw_hold_r && w_hold_r && !bvalid_r;
  assign busy = state_r != nvt_pkg::ST_IDLE;
  assign prog_end = state_r == nvt_pkg::ST_PROG && timer_r == 16'h0000;
  assign tbl_go = wr_en && aw_addr_r == nvt_pkg::OFF_TCMD && w_strb_r[0];
  assign tbl_cmd = w_data_r[2:0];
  assign tbl_addr = (tbl_cmd[2:1] == nvt_pkg::PTR_PREINC) ?
    ptr_step(ptr_r, 1'b0) : ptr_r;
  // Start needs permit; and a fresh unlock.
  assign start_ok = wr_en && aw_addr_r == nvt_pkg::OFF_CTRL &&
    w_strb_r[0] && w_data_r[nvt_pkg::CB_WR] && ctrl_r.permit &&
    unlock_r == 2'h2 && !busy;

  // Write address and data are held independently, in either order.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end else if (wr_en) begin
        aw_hold_r <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end else if (wr_en) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Write response is raised on the same edge as the register write.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      bvalid_r <= 1'b0;
      bresp_r <= nvt_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid_r <= 1'b1;
      bresp_r <= mapped(aw_addr_r) ? nvt_pkg::RESP_OKAY :
        nvt_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read data is registered; unmapped offsets answer SLVERR and zero.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= nvt_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_r <= 1'b1;
      rresp_r <= mapped(S_AXI_ARADDR) ? nvt_pkg::RESP_OKAY :
        nvt_pkg::RESP_SLVERR;
      case (S_AXI_ARADDR)
        nvt_pkg::OFF_CTRL: begin
          rdata_r <= {24'h000000, ctrl_r.pgm, ctrl_r.cfg, 1'b0,
            ctrl_r.free, ctrl_r.abort, ctrl_r.permit, ctrl_r.wr,
            ctrl_r.rd};
        end
        // The unlock port has no storage and reads zero.
        nvt_pkg::OFF_UNLOCK: rdata_r <= 32'h0000_0000;
        nvt_pkg::OFF_LATCH: rdata_r <= {24'h000000, latch_r};
        nvt_pkg::OFF_PTR: rdata_r <= {10'h000, ptr_r};
        nvt_pkg::OFF_EEPROM_DATA_REG: rdata_r <= {24'h000000, eeprom_data_reg_r};
        nvt_pkg::OFF_EEADDR: rdata_r <= {24'h000000, eeaddr_r};
        nvt_pkg::OFF_STATUS: begin
          rdata_r <= {30'h00000000, busy, done_r};
        end
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // Unlock tracker: keys must be the last two writes before the start.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      unlock_r <= 2'h0;
    end else if (wr_en) begin
      // Any other write breaks the sequence.
      if (aw_addr_r == nvt_pkg::OFF_UNLOCK &&
          w_data_r[7:0] == nvt_pkg::UNLOCK_KEY1) begin
        unlock_r <= 2'h1;
      end else if (aw_addr_r == nvt_pkg::OFF_UNLOCK && unlock_r == 2'h1
          && w_data_r[7:0] == nvt_pkg::UNLOCK_KEY2) begin
        unlock_r <= 2'h2;
      end else begin
        unlock_r <= 2'h0;
      end
    end
  end

  // Control register; a hardware clear beats a software set for the start and the erase enable.
  always_ff @(posedge CLK) begin
    if (PWR_ON_RST) begin
      ctrl_r <= '0;
    end else if (SYS_RST) begin
      // A reset during programming leaves the abort flag set.
      // Space selects survive so the failure can be traced.
      ctrl_r.abort <= ctrl_r.abort | busy;
      ctrl_r.free <= 1'b0;
      ctrl_r.permit <= 1'b0;
      ctrl_r.wr <= 1'b0;
      ctrl_r.rd <= 1'b0;
    end else begin
      // Read start clears after its single cycle.
      if (ctrl_r.rd) begin
        ctrl_r.rd <= 1'b0;
      end
      if (wr_en && aw_addr_r == nvt_pkg::OFF_CTRL && w_strb_r[0]) begin
        ctrl_r.pgm <= w_data_r[nvt_pkg::CB_PGM];
        ctrl_r.cfg <= w_data_r[nvt_pkg::CB_CFG];
        ctrl_r.free <= w_data_r[nvt_pkg::CB_FREE];
        ctrl_r.abort <= w_data_r[nvt_pkg::CB_ABORT];
        // Dropping permit does not touch a running write.
        ctrl_r.permit <= w_data_r[nvt_pkg::CB_PERMIT];
        // Read start refused while flash is selected.
        // The select being written decides, so one write cannot do both.
        if (w_data_r[nvt_pkg::CB_RD] && !w_data_r[nvt_pkg::CB_PGM] &&
            !busy) begin
          ctrl_r.rd <= 1'b1;
        end
        // Write start only taken when permitted.
        if (start_ok) begin
          ctrl_r.wr <= 1'b1;
        end
      end
      // Start and erase enable clear with the done flag.
      if (prog_end) begin
        ctrl_r.wr <= 1'b0;
        if (erase_r) begin
          ctrl_r.free <= 1'b0;
        end
      end
    end
  end

  // Done flag: software clears by writing zero; a new completion wins.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      done_r <= 1'b0;
    end else if (prog_end) begin
      done_r <= 1'b1;
    end else if (wr_en && aw_addr_r == nvt_pkg::OFF_STATUS &&
        w_strb_r[0] && !w_data_r[nvt_pkg::SB_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // Programming sequencer with its internal timer.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      state_r <= nvt_pkg::ST_IDLE;
      timer_r <= 16'h0000;
      tgt_r <= nvt_pkg::TGT_EE;
      erase_r <= 1'b0;
      prog_ptr_r <= '0;
    end else begin
      case (state_r)
        nvt_pkg::ST_IDLE: begin
          if (start_ok) begin
            // Config select overrides; else program select.
            if (ctrl_r.cfg) begin
              tgt_r <= nvt_pkg::TGT_CFG;
            end else if (ctrl_r.pgm) begin
              tgt_r <= nvt_pkg::TGT_FLASH;
            end else begin
              tgt_r <= nvt_pkg::TGT_EE;
            end
            // Erase enable turns a flash start into an erase.
            erase_r <= ctrl_r.free;
            prog_ptr_r <= ptr_r;
            // Timer loaded here, not by firmware.
            timer_r <= 16'(PROG_CYCLES - 1);
            state_r <= nvt_pkg::ST_PROG;
          end
        end
        nvt_pkg::ST_PROG: begin
          // Operation ends itself when the timer expires.
          if (timer_r == 16'h0000) begin
            state_r <= nvt_pkg::ST_DONE;
          end else begin
            timer_r <= timer_r - 16'h0001;
          end
        end
        nvt_pkg::ST_DONE: state_r <= nvt_pkg::ST_IDLE;
        default: state_r <= nvt_pkg::ST_IDLE;
      endcase
    end
  end

  // Table latch and pointer, moved by bus writes and table commands.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      latch_r <= 8'h00;
      ptr_r <= '0;
    end else if (tbl_go) begin
      // Table read fetches the addressed byte; into latch.
      if (!tbl_cmd[0]) begin
        latch_r <= table_byte(tbl_addr);
      end
      // Pointer update per the command's mode.
      case (nvt_pkg::nvt_ptr_mode_t'(tbl_cmd[2:1]))
        nvt_pkg::PTR_KEEP: ptr_r <= ptr_r;
        nvt_pkg::PTR_POSTINC: ptr_r <= ptr_step(ptr_r, 1'b0);
        nvt_pkg::PTR_POSTDEC: ptr_r <= ptr_step(ptr_r, 1'b1);
        nvt_pkg::PTR_PREINC: ptr_r <= tbl_addr;
        default: ptr_r <= ptr_r;
      endcase
    end else if (wr_en) begin
      if (aw_addr_r == nvt_pkg::OFF_LATCH && w_strb_r[0]) begin
        latch_r <= w_data_r[7:0];
      end
      // Pointer is 22 bits, byte lanes 0 to 2.
      if (aw_addr_r == nvt_pkg::OFF_PTR) begin
        if (w_strb_r[0]) begin
          ptr_r[7:0] <= w_data_r[7:0];
        end
        if (w_strb_r[1]) begin
          ptr_r[15:8] <= w_data_r[15:8];
        end
        if (w_strb_r[2]) begin
          ptr_r[21:16] <= w_data_r[21:16];
        end
      end
    end
  end

  // EEPROM data and address; both are lost on any reset.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      // Firmware must reload these after a reset.
      eeprom_data_reg_r <= 8'h00;
      eeaddr_r <= 8'h00;
    end else if (ctrl_r.rd) begin
      eeprom_data_reg_r <= ctrl_r.cfg ? cfg_mem[eeaddr_r[CFG_AW-1:0]] :
        ee_mem[eeaddr_r[EE_AW-1:0]];
    end else if (wr_en && w_strb_r[0]) begin
      if (aw_addr_r == nvt_pkg::OFF_EEPROM_DATA_REG) begin
        eeprom_data_reg_r <= w_data_r[7:0];
      end
      if (aw_addr_r == nvt_pkg::OFF_EEADDR) begin
        eeaddr_r <= w_data_r[7:0];
      end
    end
  end

  // Holding registers: filled by table writes, emptied after a write.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      for (int i = 0; i < nvt_pkg::HOLD_N; i++) begin
        hold_r[i] <= nvt_pkg::ERASED_BYTE;
      end
    end else if (prog_end && tgt_r == nvt_pkg::TGT_FLASH && !erase_r) begin
      for (int i = 0; i < nvt_pkg::HOLD_N; i++) begin
        hold_r[i] <= nvt_pkg::ERASED_BYTE;
      end
    end else if (tbl_go && tbl_cmd[0]) begin
      // Low three pointer bits pick the holding register.
      // Any byte address is accepted, aligned or not.
      hold_r[tbl_addr[2:0]] <= latch_r;
    end
  end

  // Array update at the end of the timed operation; no reset on storage.
  // Bytes are stored as given, with no check of their content.
  always_ff @(posedge CLK) begin
    if (prog_end && !SYS_RST && !PWR_ON_RST) begin
      case (tgt_r)
        nvt_pkg::TGT_EE: ee_mem[eeaddr_r[EE_AW-1:0]] <= eeprom_data_reg_r;
        nvt_pkg::TGT_CFG: cfg_mem[prog_ptr_r[CFG_AW-1:0]] <= latch_r;
        nvt_pkg::TGT_FLASH: begin
          // Erase is always one 64-byte block; never bulk.
          // Pointer bits 5..0 are ignored for the erase.
          if (erase_r) begin
            for (int i = 0; i < nvt_pkg::ERASE_N; i++) begin
              flash_mem[{prog_ptr_r[FLASH_AW-1:6], 6'(i)}] <=
                nvt_pkg::ERASED_BYTE;
            end
          end else begin
            // Write is one 8-byte block from the holding registers.
            for (int i = 0; i < nvt_pkg::HOLD_N; i++) begin
              flash_mem[{prog_ptr_r[FLASH_AW-1:3], 3'(i)}] <= hold_r[i];
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Fetch port; the core stalls while flash or config programs.
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      FETCH_WORD <= 16'h0000;
      FETCH_STALL <= 1'b0;
    end else begin
      FETCH_WORD <= {flash_mem[{FETCH_ADDR, 1'b1}],
        flash_mem[{FETCH_ADDR, 1'b0}]};
      FETCH_STALL <= start_ok ? (ctrl_r.pgm || ctrl_r.cfg) :
        (state_r == nvt_pkg::ST_PROG && !prog_end &&
        tgt_r != nvt_pkg::TGT_EE);
    end
  end

endmodule
`default_nettype wire

// ### tb/nvt_table_access_asserts.sv
// Port-level concurrent checks for the table access block.
`default_nettype none
module nvt_table_access_asserts #(
  parameter int PROG_CYCLES = 4
) (
  // Clock and resets.
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PWR_ON_RST,
  // Register bus handshakes and answers.
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Fetch stall and completion flag.
  input wire logic FETCH_STALL,
  input wire logic NVM_DONE_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // Length of the current stall run; a counter avoids a long repetition.
  int run_n;
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST || !FETCH_STALL) begin
      run_n <= 0;
    end else begin
      run_n <= run_n + 1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST || PWR_ON_RST);
  // A reset cuts a stall short, so the edge after it is left out.
  stall_len_a: assert property (!$past(SYS_RST) &&
    $fell(FETCH_STALL) |-> run_n == PROG_CYCLES)
    else $error("stall run length wrong");
  done_end_a: assert property (!$past(SYS_RST) &&
    $fell(FETCH_STALL) |-> NVM_DONE_IRQ)
    else $error("done flag not set at end of stall");
  done_clear_a: assert property (!$past(SYS_RST) &&
    $fell(NVM_DONE_IRQ) |-> S_AXI_BVALID)
    else $error("done flag dropped without a write");
  unlock_zero_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR == nvt_pkg::OFF_UNLOCK |=> S_AXI_RVALID &&
    S_AXI_RDATA == 32'h0) else $error("unlock port read not zero");
  ptr_width_a: assert property (S_AXI_RVALID |->
    S_AXI_RDATA[31:22] == 10'h0) else $error("read data upper bits set");
  bad_addr_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR > nvt_pkg::OFF_STATUS |=> S_AXI_RRESP ==
    nvt_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
  write_block_a: assert property (S_AXI_BVALID |->
    !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write taken early");
endmodule
`default_nettype wire

// ### tb/nvt_core_model.sv
// Fetch side of the processor core facing the table access block.
`default_nettype none
module nvt_core_model #(
  parameter int AW = 11
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Word the bench wants fetched next.
  input wire logic [AW-1:0] want_addr,
  // Fetch port of the block.
  input wire logic stall,
  output logic [AW-1:0] fetch_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // A stalled core issues no new fetch, so the address freezes.
  // fetch holds still
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_addr <= '0;
    end else if (!stall) begin
      fetch_addr <= want_addr;
    end
  end
endmodule
`default_nettype wire

// ### tb/nvt_table_access_bench.sv
// Register-level self-checking tests of the table access block.
`default_nettype none
module nvt_table_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, resets and bus drive, all given a value at time zero.
  logic clk = 1'h0, sys_rst = 1'h1, por = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, stall, done_irq;
  logic [10:0] fa = 11'h0, fetch_addr;
  logic [15:0] fword;
  int err_total = 0, n_compared = 0;
  // Table command, expected latch and pointer for each pointer mode.
  logic [7:0] md [4] = '{8'h00, 8'h02, 8'h04, 8'h06};
  logic [7:0] el [4] = '{8'hA5, 8'hA5, 8'h5A, 8'h5A};
  logic [7:0] ep [4] = '{8'h10, 8'h11, 8'h10, 8'h11};
  nvt_table_access #(.PROG_CYCLES(4)) dut_u (
    .CLK(clk), .SYS_RST(sys_rst), .PWR_ON_RST(por),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .FETCH_ADDR(fetch_addr), .FETCH_WORD(fword),
    .FETCH_STALL(stall), .NVM_DONE_IRQ(done_irq));
  nvt_core_model #(.AW(11)) core_u (.clk(clk), .rst(sys_rst),
    .want_addr(fa), .stall(stall), .fetch_addr(fetch_addr));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // Readiness is looked at mid-cycle, where it is settled for the edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, ta, tw;
    int n;
    pa = 1'h1;
    pw = 1'h1;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while ((pa || pw) && n < 40) begin
      @(negedge clk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge clk);
      n++;
      if (ta) begin
        pa = 1'h0;
        awvalid <= 1'h0;
      end
      if (tw) begin
        pw = 1'h0;
        wvalid <= 1'h0;
      end
    end
    bready <= 1'h1;
    do begin
      @(negedge clk);
      ta = bvalid;
      resp = bresp;
      @(posedge clk);
      n++;
    end while (!ta && n < 80);
    if (!ta) err_total++;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic t;
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
      n++;
    end while (!t && n < 40);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do begin
      @(negedge clk);
      t = rvalid;
      v = rdata;
      resp = rresp;
      @(posedge clk);
      n++;
    end while (!t && n < 80);
    if (!t) err_total++;
    rready <= 1'h0;
  endtask
  // Unlock keys go straight before the start write, as the block demands.
  // unlock then start
  task automatic prog(input logic [7:0] c);
    wr(nvt_pkg::OFF_CTRL, {24'h0, c | 8'h04});
    wr(nvt_pkg::OFF_UNLOCK, {24'h0, nvt_pkg::UNLOCK_KEY1});
    wr(nvt_pkg::OFF_UNLOCK, {24'h0, nvt_pkg::UNLOCK_KEY2});
    wr(nvt_pkg::OFF_CTRL, {24'h0, c | 8'h06});
  endtask
  // Polls the status word under a bound, then clears the done flag.
  task automatic wait_done;
    int n;
    n = 0;
    d = 32'h0;
    while (d[nvt_pkg::SB_DONE] !== 1'h1 && n < 50) begin
      rd(nvt_pkg::OFF_STATUS, d);
      n++;
    end
    chk("done flag", 32'h1, 32'(done_irq));
    wr(nvt_pkg::OFF_STATUS, 32'h0);
    @(negedge clk);
    chk("done cleared", 32'h0, 32'(done_irq));
    @(posedge clk);
  endtask
  // The word arrives one cycle after the model presents its address.
  task automatic fetch(input logic [10:0] a, input logic [15:0] e);
    fa <= a;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("fetch word", {16'h0, e}, {16'h0, fword});
    @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    por <= 1'h0;
    @(posedge clk);
    // Unmapped places are refused and read as zero.
    rd(8'h20, d);
    chk("bad read resp", 32'h2, 32'(resp));
    wr(8'h20, 32'h1);
    chk("bad write resp", 32'h2, 32'(resp));
    wr(nvt_pkg::OFF_UNLOCK, 32'h55);
    rd(nvt_pkg::OFF_UNLOCK, d);
    chk("unlock port", 32'h0, d);
    wr(nvt_pkg::OFF_PTR, 32'hFFFFFFFF);
    rd(nvt_pkg::OFF_PTR, d);
    chk("pointer width", 32'h3FFFFF, d);
    // Start refused first without permit, then without the keys.
    wr(nvt_pkg::OFF_EEADDR, 32'h5);
    wr(nvt_pkg::OFF_EEPROM_DATA_REG, 32'h21);
    prog(8'h00);
    wr(nvt_pkg::OFF_CTRL, 32'h0);
    wait_done;
    wr(nvt_pkg::OFF_UNLOCK, 32'h55);
    wr(nvt_pkg::OFF_UNLOCK, 32'hAA);
    wr(nvt_pkg::OFF_CTRL, 32'h2);
    rd(nvt_pkg::OFF_CTRL, d);
    chk("start without permit", 32'h0, d);
    wr(nvt_pkg::OFF_CTRL, 32'h4);
    wr(nvt_pkg::OFF_CTRL, 32'h6);
    rd(nvt_pkg::OFF_CTRL, d);
    chk("start without keys", 32'h4, d);
    wr(nvt_pkg::OFF_EEPROM_DATA_REG, 32'h3C);
    prog(8'h00);
    wait_done;
    rd(nvt_pkg::OFF_CTRL, d);
    chk("write start cleared", 32'h4, d);
    wr(nvt_pkg::OFF_EEPROM_DATA_REG, 32'h0);
    wr(nvt_pkg::OFF_CTRL, 32'h1);
    rd(nvt_pkg::OFF_EEPROM_DATA_REG, d);
    chk("eeprom read", 32'h3C, d);
    wr(nvt_pkg::OFF_EEPROM_DATA_REG, 32'h0);
    wr(nvt_pkg::OFF_CTRL, 32'h81);
    rd(nvt_pkg::OFF_CTRL, d);
    chk("flash read start", 32'h80, d);
    rd(nvt_pkg::OFF_EEPROM_DATA_REG, d);
    chk("flash read refused", 32'h0, d);
    // Two holding bytes, block write, permit dropped while busy.
    wr(nvt_pkg::OFF_PTR, 32'h10);
    wr(nvt_pkg::OFF_LATCH, 32'hA5);
    wr(nvt_pkg::OFF_TCMD, 32'h3);
    wr(nvt_pkg::OFF_LATCH, 32'h5A);
    wr(nvt_pkg::OFF_TCMD, 32'h3);
    rd(nvt_pkg::OFF_PTR, d);
    chk("pointer post inc", 32'h12, d);
    prog(8'h80);
    @(negedge clk);
    chk("fetch stalled", 32'h1, 32'(stall));
    @(posedge clk);
    wr(nvt_pkg::OFF_CTRL, 32'h80);
    wait_done;
    fetch(11'h8, 16'h5AA5);
    fetch(11'h9, 16'hFFFF);
    wr(nvt_pkg::OFF_PTR, 32'h10);
    for (int i = 0; i < 4; i++) begin
      wr(nvt_pkg::OFF_TCMD, {24'h0, md[i]});
      rd(nvt_pkg::OFF_LATCH, d);
      chk("table latch", {24'h0, el[i]}, d);
      rd(nvt_pkg::OFF_PTR, d);
      chk("table pointer", {24'h0, ep[i]}, d);
    end
    // Erase from a pointer whose low six bits are all set.
    wr(nvt_pkg::OFF_PTR, 32'h3F);
    prog(8'h90);
    wait_done;
    rd(nvt_pkg::OFF_CTRL, d);
    chk("erase enable cleared", 32'h84, d);
    fetch(11'h8, 16'hFFFF);
    wr(nvt_pkg::OFF_PTR, 32'h2);
    wr(nvt_pkg::OFF_LATCH, 32'h77);
    prog(8'h40);
    wait_done;
    wr(nvt_pkg::OFF_PTR, 32'h200002);
    wr(nvt_pkg::OFF_TCMD, 32'h0);
    rd(nvt_pkg::OFF_LATCH, d);
    chk("config byte", 32'h77, d);
    // A device reset in mid-write leaves the abort trace.
    wr(nvt_pkg::OFF_EEPROM_DATA_REG, 32'h11);
    prog(8'h80);
    sys_rst <= 1'h1;
    @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(nvt_pkg::OFF_CTRL, d);
    chk("abort flag", 32'h88, d & 32'hC8);
    rd(nvt_pkg::OFF_EEPROM_DATA_REG, d);
    chk("eeprom data reset", 32'h0, d);
    rd(nvt_pkg::OFF_PTR, d);
    chk("pointer reset", 32'h0, d);
    close_out;
  end
endmodule
bind nvt_table_access nvt_table_access_asserts #(.PROG_CYCLES(PROG_CYCLES))
  chk_u (.CLK, .SYS_RST, .PWR_ON_RST, .S_AXI_AWREADY, .S_AXI_WREADY,
  .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
  .S_AXI_RVALID, .S_AXI_RREADY, .FETCH_STALL, .NVM_DONE_IRQ);
`default_nettype wire
